// *** logic/fe_defines.svh ***
// register indices, reset values and timing counts of the supervisor
`ifndef FE_DEFINES_SVH
`define FE_DEFINES_SVH
`define FE_IDX_WINDOW 12'h394
`define FE_IDX_TIMEOUT 12'h395
`define FE_IDX_HOME_OFS 12'h39e
`define FE_IDX_POS_PROF 12'h39f
`define FE_IDX_TRQ_PROF 12'h3a0
`define FE_IDX_HOME_METH 12'h3a1
`define FE_IDX_SW_SPEED 12'h3a2
`define FE_IDX_ZERO_SPEED 12'h3a3
`define FE_IDX_LIVE 12'h3a9
`define FE_WINDOW_RST 32'h0000_0000
`define FE_TIMEOUT_RST 16'h0002
`define FE_TIMEOUT_MIN 16'h0002
`define FE_TIMEOUT_MAX 16'h7fff
`define FE_PROF_LINEAR 16'h0000
`define FE_PROF_JERKFREE 16'h0002
`define FE_TRQ_PROF_VAL 16'h0000
`define FE_METH_RST 8'h01
`define FE_METH_MIN 8'h01
`define FE_METH_MAX 8'h23
`define FE_CLK_MHZ 25
`define FE_TICK_US 1000
`define FE_CYC_PER_MS (`FE_TICK_US * `FE_CLK_MHZ)
`endif

// *** logic/fe_fault_timer.sv ***
// millisecond delay between a following error and its event action
`include "fe_defines.svh"
module fe_fault_timer #(
    parameter int unsigned CYC_PER_MS = `FE_CYC_PER_MS
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic fault_in,
    input wire logic [15:0] timeout_in,
    output logic action_out
);
    import fe_pkg::*;
    logic [31:0] div_q;
    logic [31:0] next_div;
    logic [15:0] ms_q;
    logic [15:0] next_ms;
    logic act_q;
    logic next_act;

    // divider restarts with each fault, so the delay is never short
    always_comb begin
        next_div = div_q;
        next_ms = ms_q;
        next_act = act_q;
        if (!fault_in) begin
            next_div = 32'h0000_0000;
            next_ms = 16'h0000;
            next_act = 1'b0;
        end else if (!act_q) begin
            if (div_q == 32'(CYC_PER_MS - 1)) begin
                next_div = 32'h0000_0000;
                next_ms = ms_q + 16'h0001;
                if (next_ms >= timeout_in) begin
                    next_act = 1'b1; // R03
                end
            end else begin
                next_div = div_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            div_q <= 32'h0000_0000;
            ms_q <= 16'h0000;
            act_q <= 1'b0;
        end else begin
            div_q <= next_div;
            ms_q <= next_ms;
            act_q <= next_act;
        end
    end

    assign action_out = act_q;
endmodule : fe_fault_timer

// *** logic/fe_homing_seq.sv ***
// two-stage homing sequencer: switch search then zero search
`include "fe_defines.svh"
module fe_homing_seq (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic [7:0] method_in,
    input wire logic switch_in,
    input wire logic index_in,
    input wire logic [31:0] switch_speed_in,
    input wire logic [31:0] zero_speed_in,
    output fe_pkg::fe_home_state_t state_out,
    output logic [31:0] speed_out,
    output logic done_out,
    output logic refused_out
);
    import fe_pkg::*;
    fe_home_state_t state_q;
    fe_home_state_t next_state;
    logic [31:0] speed_q;
    logic [31:0] next_speed;
    logic method_ok;

    assign method_ok = ($signed(method_in) >= $signed(`FE_METH_MIN))
        && ($signed(method_in) <= $signed(`FE_METH_MAX)); // R10

    always_comb begin
        next_state = state_q;
        unique case (state_q)
            FE_HOME_IDLE, FE_HOME_DONE: begin
                if (start_in && method_ok) begin
                    next_state = FE_HOME_SWITCH;
                end
            end
            FE_HOME_SWITCH: begin
                if (switch_in) begin
                    next_state = FE_HOME_ZERO;
                end
            end
            FE_HOME_ZERO: begin
                if (index_in) begin
                    next_state = FE_HOME_DONE;
                end
            end
            default: next_state = FE_HOME_IDLE;
        endcase
        next_speed = 32'h0000_0000;
        if (next_state == FE_HOME_SWITCH) begin
            next_speed = switch_speed_in; // R11
        end else if (next_state == FE_HOME_ZERO) begin
            next_speed = zero_speed_in; // R12
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_q <= FE_HOME_IDLE;
            speed_q <= 32'h0000_0000;
        end else begin
            state_q <= next_state;
            speed_q <= next_speed;
        end
    end

    assign state_out = state_q;
    assign speed_out = speed_q;
    assign done_out = (state_q == FE_HOME_ZERO) && index_in;
    assign refused_out = start_in && !method_ok
        && ((state_q == FE_HOME_IDLE) || (state_q == FE_HOME_DONE));
endmodule : fe_homing_seq

// *** logic/fe_pkg.sv ***
// types shared by the supervisor and its homing sequencer
package fe_pkg;
    typedef enum logic [3:0] {
        FE_HOME_IDLE = 4'h1,
        FE_HOME_SWITCH = 4'h2,
        FE_HOME_ZERO = 4'h4,
        FE_HOME_DONE = 4'h8
    } fe_home_state_t;
endpackage : fe_pkg

// *** logic/fe_servo_supervisor.sv ***
// following-error supervision, homing and profile parameters
// Behaviour
// [R01] event raised when error exceeds the unsigned window, in counts
// [R02] error check only in position mode; otherwise event stays low
// [R03] action follows the event after the timeout in ms, range 2..32767
// [R04] read-only signed live error equals target minus measured position
// [R05] on homing completion position becomes zero minus home offset
// [R06] later positions are taken relative to that new zero
// [R07] position profile select: 0 linear, 2 jerk-free, default 0
// [R08] position profile select is volatile and returns to default at reset
// [R09] torque profile select is read-only and always reads 0
// [R10] homing method is signed 8-bit; host writes 1..35 to choose it
// [R11] first homing stage moves at the switch-search speed
// [R12] second homing stage searches zero at the zero-search speed
// [R13] magnitude of error compared each update so both signs trip
`include "fe_defines.svh"
module fe_servo_supervisor #(
    parameter int unsigned CYC_PER_MS = `FE_CYC_PER_MS
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [11:0] param_idx_in,
    input wire logic param_wr_in,
    input wire logic param_rd_in,
    input wire logic [31:0] param_wdata_in,
    output logic [31:0] param_rdata_out,
    output logic param_ack_out,
    output logic param_err_out,
    input wire logic update_in,
    input wire logic pos_mode_in,
    input wire logic [31:0] target_pos_in,
    input wire logic [31:0] measured_pos_in,
    input wire logic home_start_in,
    input wire logic home_switch_in,
    input wire logic index_pulse_in,
    output logic fe_event_out,
    output logic fe_action_out,
    output logic [31:0] cur_pos_out,
    output logic [31:0] home_speed_out,
    output fe_pkg::fe_home_state_t home_state_out,
    output logic home_done_out,
    output logic home_refused_out,
    output logic [15:0] pos_profile_out
);
    import fe_pkg::*;

    logic [31:0] window;
    logic [31:0] next_window;
    logic [15:0] timeout;
    logic [15:0] next_timeout;
    logic [31:0] home_offset;
    logic [31:0] next_home_offset;
    logic [15:0] pos_prof;
    logic [15:0] next_pos_prof;
    logic [7:0] meth;
    logic [7:0] next_meth;
    logic [31:0] sw_speed;
    logic [31:0] next_sw_speed;
    logic [31:0] zero_speed;
    logic [31:0] next_zero_speed;
    logic [31:0] live;
    logic [31:0] next_live;
    logic fe_evt;
    logic next_fe_evt;
    logic [31:0] adj;
    logic [31:0] next_adj;
    logic [31:0] cur_pos;
    logic [31:0] next_cur_pos;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic ack;
    logic next_ack;
    logic err;
    logic next_err;
    logic [1:0] sw_sync;
    logic [1:0] idx_sync;
    logic [31:0] diff;
    logic [31:0] mag;
    logic hit;
    logic wr_en;
    logic home_done;

    // pins from the machine are asynchronous
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sw_sync <= 2'h0;
            idx_sync <= 2'h0;
        end else begin
            sw_sync <= {sw_sync[0], home_switch_in};
            idx_sync <= {idx_sync[0], index_pulse_in};
        end
    end

    assign diff = target_pos_in - measured_pos_in; // R04
    assign mag = diff[31] ? (32'h0000_0000 - diff) : diff; // R13
    assign hit = mag > window; // R01
    assign wr_en = param_wr_in;

    always_comb begin
        next_window = window;
        next_timeout = timeout;
        next_home_offset = home_offset;
        next_pos_prof = pos_prof;
        next_meth = meth;
        next_sw_speed = sw_speed;
        next_zero_speed = zero_speed;
        next_rdata = rdata;
        next_ack = param_wr_in || param_rd_in;
        next_err = 1'b0;
        if (wr_en) begin
            unique case (param_idx_in)
                `FE_IDX_WINDOW: next_window = param_wdata_in;
                `FE_IDX_TIMEOUT: begin
                    // out-of-range delays are clamped, not refused
                    if (param_wdata_in[15:0] < `FE_TIMEOUT_MIN) begin
                        next_timeout = `FE_TIMEOUT_MIN; // R03
                    end else if (param_wdata_in[15:0] > `FE_TIMEOUT_MAX) begin
                        next_timeout = `FE_TIMEOUT_MAX; // R03
                    end else begin
                        next_timeout = param_wdata_in[15:0];
                    end
                end
                `FE_IDX_HOME_OFS: next_home_offset = param_wdata_in;
                `FE_IDX_POS_PROF: begin
                    if (param_wdata_in[15:0] == `FE_PROF_LINEAR
                        || param_wdata_in[15:0] == `FE_PROF_JERKFREE) begin
                        next_pos_prof = param_wdata_in[15:0]; // R07
                    end else begin
                        next_err = 1'b1;
                    end
                end
                `FE_IDX_HOME_METH: next_meth = param_wdata_in[7:0]; // R10
                `FE_IDX_SW_SPEED: next_sw_speed = param_wdata_in;
                `FE_IDX_ZERO_SPEED: next_zero_speed = param_wdata_in;
                default: next_err = 1'b1;
            endcase
        end else if (param_rd_in) begin
            next_rdata = 32'h0000_0000;
            unique case (param_idx_in)
                `FE_IDX_WINDOW: next_rdata = window;
                `FE_IDX_TIMEOUT: next_rdata = {16'h0000, timeout};
                `FE_IDX_HOME_OFS: next_rdata = home_offset;
                `FE_IDX_POS_PROF: next_rdata = {16'h0000, pos_prof};
                `FE_IDX_TRQ_PROF: next_rdata = {16'h0000, `FE_TRQ_PROF_VAL}; // R09
                `FE_IDX_HOME_METH: next_rdata = {24'h00_0000, meth};
                `FE_IDX_SW_SPEED: next_rdata = sw_speed;
                `FE_IDX_ZERO_SPEED: next_rdata = zero_speed;
                `FE_IDX_LIVE: next_rdata = live; // R04
                default: next_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            window <= `FE_WINDOW_RST;
            timeout <= `FE_TIMEOUT_RST;
            home_offset <= 32'h0000_0000;
            pos_prof <= `FE_PROF_LINEAR; // R08
            meth <= `FE_METH_RST;
            sw_speed <= 32'h0000_0000;
            zero_speed <= 32'h0000_0000;
            rdata <= 32'h0000_0000;
            ack <= 1'b0;
            err <= 1'b0;
        end else begin
            window <= next_window;
            timeout <= next_timeout;
            home_offset <= next_home_offset;
            pos_prof <= next_pos_prof;
            meth <= next_meth;
            sw_speed <= next_sw_speed;
            zero_speed <= next_zero_speed;
            rdata <= next_rdata;
            ack <= next_ack;
            err <= next_err;
        end
    end

    // error and position tracking
    always_comb begin
        next_live = live;
        next_fe_evt = fe_evt;
        if (update_in) begin
            next_live = diff; // R04
            next_fe_evt = pos_mode_in && hit; // R01
        end
        if (!pos_mode_in) begin
            next_fe_evt = 1'b0; // R02
        end
        next_adj = adj;
        if (home_done) begin
            next_adj = 32'h0000_0000 - home_offset - measured_pos_in; // R05
        end
        next_cur_pos = measured_pos_in + next_adj; // R06
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            live <= 32'h0000_0000;
            fe_evt <= 1'b0;
            adj <= 32'h0000_0000;
            cur_pos <= 32'h0000_0000;
        end else begin
            live <= next_live;
            fe_evt <= next_fe_evt;
            adj <= next_adj;
            cur_pos <= next_cur_pos;
        end
    end

    fe_fault_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .fault_in(fe_evt),
        .timeout_in(timeout),
        .action_out(fe_action_out)
    );

    fe_homing_seq u_home (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .start_in(home_start_in),
        .method_in(meth),
        .switch_in(sw_sync[1]),
        .index_in(idx_sync[1]),
        .switch_speed_in(sw_speed),
        .zero_speed_in(zero_speed),
        .state_out(home_state_out),
        .speed_out(home_speed_out),
        .done_out(home_done),
        .refused_out(home_refused_out)
    );

    assign param_rdata_out = rdata;
    assign param_ack_out = ack;
    assign param_err_out = err;
    assign fe_event_out = fe_evt;
    assign cur_pos_out = cur_pos;
    assign home_done_out = home_done;
    assign pos_profile_out = pos_prof;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    chk_live_diff: assert property (update_in |=> // R04
        live == $past(target_pos_in) - $past(measured_pos_in))
        else $error("live error not target minus measured");
    chk_event_raise: assert property (update_in && pos_mode_in && hit |=> fe_evt) // R01
        else $error("following error event not raised");
    chk_event_sign: assert property (update_in && pos_mode_in // R13
        && (($signed(diff) < 0) ? (32'h0000_0000 - diff) : diff) <= window |=> !fe_evt)
        else $error("following error event raised inside window");
    chk_event_mode: assert property (!pos_mode_in |=> !fe_evt) // R02
        else $error("following error event outside position mode");
    chk_action_delay: assert property ($rose(fe_evt) |-> !fe_action_out [*2]) // R03
        else $error("event action without delay");
    chk_action_cause: assert property (fe_action_out |-> $past(fe_evt)) // R03
        else $error("event action without event");
    chk_home_zero: assert property (home_done |=> cur_pos == -$past(home_offset)) // R05
        else $error("homed position not zero minus offset");
    chk_home_rel: assert property (!home_done && !$past(reset_in) |=> // R06
        cur_pos - $past(measured_pos_in) == $past(cur_pos) - $past(measured_pos_in, 2))
        else $error("position offset moved outside homing");
    chk_profile_legal: assert property (pos_prof == `FE_PROF_LINEAR // R07
        || pos_prof == `FE_PROF_JERKFREE)
        else $error("illegal position profile value");
    chk_torque_zero: assert property (param_rd_in && !param_wr_in // R09
        && param_idx_in == `FE_IDX_TRQ_PROF |=> rdata == 32'h0000_0000)
        else $error("torque profile not zero");
    chk_method_range: assert property (home_refused_out |=> home_state_out != FE_HOME_SWITCH) // R10
        else $error("homing started with bad method");
    chk_switch_speed: assert property (home_state_out == FE_HOME_SWITCH // R11
        |-> home_speed_out == $past(sw_speed))
        else $error("switch search speed wrong");
    chk_zero_speed: assert property (home_state_out == FE_HOME_ZERO // R12
        |-> home_speed_out == $past(zero_speed))
        else $error("zero search speed wrong");

    cov_event: cover property ($rose(fe_evt));
    cov_action: cover property ($rose(fe_action_out));
    cov_homed: cover property (home_done);
    cov_refused: cover property (home_refused_out);
endmodule : fe_servo_supervisor

// *** tb/fe_host_model.sv ***
// behavioural host issuing parameter reads and writes
module fe_host_model (
    input wire logic mclk_in,
    output logic wr_out,
    output logic rd_out,
    output logic [11:0] idx_out,
    output logic [31:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        idx_out = 12'h000;
        wdata_out = 32'h0000_0000;
    end
    // strobe is one cycle; index and data hold until the ack edge
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] d);
        @(posedge mclk_in);
        wr_out <= wr;
        rd_out <= ~wr;
        idx_out <= idx;
        wdata_out <= d;
        @(posedge mclk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        @(posedge mclk_in);
        // released lines scrambled so stale values cannot pass
        idx_out <= ~idx;
        wdata_out <= ~d;
    endtask : xfer
endmodule : fe_host_model

// *** tb/following_error_homing_params_test.sv ***
// self-checking bench for the following-error supervisor
`include "fe_defines.svh"
module following_error_homing_params_test;
    timeunit 1ns;
    timeprecision 1ns;
    import fe_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic param_wr_in, param_rd_in, param_ack_out, param_err_out;
    logic [11:0] param_idx_in;
    logic [31:0] param_wdata_in, param_rdata_out, target_pos_in, measured_pos_in;
    logic update_in, pos_mode_in, home_start_in, home_switch_in, index_pulse_in;
    logic fe_event_out, fe_action_out, home_done_out, home_refused_out;
    logic [31:0] cur_pos_out, home_speed_out;
    logic [15:0] pos_profile_out;
    fe_home_state_t home_state_out;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] lfsr_q = 32'h0000_605d;
    logic [33:0] notes[$];

    initial forever #20 mclk_in = ~mclk_in;

    fe_servo_supervisor #(.CYC_PER_MS(4)) dut (
        .mclk_in, .reset_in, .param_idx_in, .param_wr_in, .param_rd_in, .param_wdata_in,
        .param_rdata_out, .param_ack_out, .param_err_out, .update_in, .pos_mode_in,
        .target_pos_in, .measured_pos_in, .home_start_in, .home_switch_in, .index_pulse_in,
        .fe_event_out, .fe_action_out, .cur_pos_out, .home_speed_out, .home_state_out,
        .home_done_out, .home_refused_out, .pos_profile_out);

    fe_host_model host (.mclk_in, .wr_out(param_wr_in), .rd_out(param_rd_in),
        .idx_out(param_idx_in), .wdata_out(param_wdata_in));

    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wr_reg(input logic [11:0] idx, input logic [31:0] d, input logic err);
        notes.push_back({1'b0, err, 32'h0000_0000});
        host.xfer(1'b1, idx, d);
    endtask : wr_reg

    task automatic rd_reg(input logic [11:0] idx, input logic [31:0] exp);
        notes.push_back({1'b1, 1'b0, exp});
        host.xfer(1'b0, idx, 32'h0000_0000);
    endtask : rd_reg

    task automatic upd(input logic [31:0] t, input logic [31:0] m);
        @(posedge mclk_in);
        target_pos_in <= t;
        measured_pos_in <= m;
        update_in <= 1'b1;
        @(posedge mclk_in);
        update_in <= 1'b0;
        @(negedge mclk_in);
    endtask : upd

    task automatic pulse_start(output logic refused);
        @(posedge mclk_in);
        home_start_in <= 1'b1;
        @(negedge mclk_in);
        refused = home_refused_out;
        @(posedge mclk_in);
        home_start_in <= 1'b0;
        @(negedge mclk_in);
    endtask : pulse_start

    task automatic wait_state(input fe_home_state_t s);
        int k;
        k = 0;
        while (home_state_out !== s && k < 8) begin
            @(negedge mclk_in);
            k++;
        end
        check(32'(home_state_out), 32'(s));
    endtask : wait_state

    // result monitor: oldest note against each acknowledge
    always @(posedge mclk_in) begin
        logic [33:0] n;
        if (param_ack_out === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h0000_0001, 32'h0000_0000);
            end else begin
                n = notes.pop_front();
                check(32'(param_err_out), 32'(n[32]));
                if (n[33]) check(param_rdata_out, n[31:0]);
            end
        end
    end

    // bound sized far above the roughly two hundred cycles of traffic
    initial begin
        repeat (5000) @(posedge mclk_in);
        errors++;
        wrap_up();
    end

    initial begin
        logic [31:0] b, ofs, s1, s2;
        logic r;
        logic [7:0] bad[3];
        int k;
        bad = '{8'h00, 8'h24, 8'hff};
        {update_in, pos_mode_in, home_start_in, home_switch_in, index_pulse_in} = 5'h00;
        target_pos_in = 32'h0000_0000;
        measured_pos_in = 32'h0000_0000;
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        rd_reg(`FE_IDX_WINDOW, 32'h0000_0000);
        rd_reg(`FE_IDX_TIMEOUT, 32'h0000_0002);
        rd_reg(`FE_IDX_POS_PROF, 32'h0000_0000);
        rd_reg(`FE_IDX_HOME_METH, 32'h0000_0001);
        wr_reg(`FE_IDX_TRQ_PROF, 32'h0000_0002, 1'b1);
        wr_reg(`FE_IDX_LIVE, 32'h0000_0005, 1'b1);
        wr_reg(12'h390, 32'h0000_0001, 1'b1);
        rd_reg(`FE_IDX_TRQ_PROF, 32'h0000_0000);
        wr_reg(`FE_IDX_POS_PROF, 32'h0000_0002, 1'b0);
        @(negedge mclk_in);
        check(32'(pos_profile_out), 32'h0000_0002);
        wr_reg(`FE_IDX_POS_PROF, 32'h0000_0001, 1'b1);
        rd_reg(`FE_IDX_POS_PROF, 32'h0000_0002);
        // timeout is clamped into its legal range
        wr_reg(`FE_IDX_TIMEOUT, 32'h0000_0000, 1'b0);
        rd_reg(`FE_IDX_TIMEOUT, 32'h0000_0002);
        wr_reg(`FE_IDX_TIMEOUT, 32'h0000_ffff, 1'b0);
        rd_reg(`FE_IDX_TIMEOUT, 32'h0000_7fff);
        wr_reg(`FE_IDX_TIMEOUT, 32'h0000_0003, 1'b0);
        wr_reg(`FE_IDX_WINDOW, 32'h0000_0064, 1'b0);
        b = rnd() & 32'h00ff_ffff;
        pos_mode_in <= 1'b1;
        upd(b + 32'h0000_0064, b);
        check(32'(fe_event_out), 32'h0000_0000);
        upd(b, b + 32'h0000_0065);
        check(32'(fe_event_out), 32'h0000_0001);
        k = 0;
        while (fe_action_out !== 1'b1 && k < 40) begin
            @(negedge mclk_in);
            k++;
        end
        check(32'(k >= 12 && k <= 13), 32'h0000_0001);
        rd_reg(`FE_IDX_LIVE, 32'hffff_ff9b);
        pos_mode_in <= 1'b0;
        @(posedge mclk_in);
        @(negedge mclk_in);
        check(32'(fe_event_out), 32'h0000_0000);
        // action register lags the event by one cycle
        @(negedge mclk_in);
        check(32'(fe_action_out), 32'h0000_0000);
        upd(b + 32'h0000_01f4, b);
        check(32'(fe_event_out), 32'h0000_0000);
        @(posedge mclk_in);
        pos_mode_in <= 1'b1;
        upd(b + 32'h0000_0065, b);
        check(32'(fe_event_out), 32'h0000_0001);
        upd(b, b);
        check(32'(fe_event_out), 32'h0000_0000);
        ofs = rnd();
        s1 = rnd();
        s2 = rnd() >> 4;
        wr_reg(`FE_IDX_HOME_OFS, ofs, 1'b0);
        wr_reg(`FE_IDX_SW_SPEED, s1, 1'b0);
        wr_reg(`FE_IDX_ZERO_SPEED, s2, 1'b0);
        for (k = 0; k < 3; k++) begin
            wr_reg(`FE_IDX_HOME_METH, {24'h00_0000, bad[k]}, 1'b0);
            rd_reg(`FE_IDX_HOME_METH, {24'h00_0000, bad[k]});
            pulse_start(r);
            check(32'(r), 32'h0000_0001);
            check(32'(home_state_out), 32'(FE_HOME_IDLE));
        end
        wr_reg(`FE_IDX_HOME_METH, 32'h0000_0023, 1'b0);
        pulse_start(r);
        check(32'(r), 32'h0000_0000);
        check(32'(home_state_out), 32'(FE_HOME_SWITCH));
        check(home_speed_out, s1);
        @(posedge mclk_in);
        home_switch_in <= 1'b1;
        wait_state(FE_HOME_ZERO);
        check(home_speed_out, s2);
        @(posedge mclk_in);
        index_pulse_in <= 1'b1;
        k = 0;
        while (home_done_out !== 1'b1 && k < 8) begin
            @(negedge mclk_in);
            k++;
        end
        check(32'(k < 8), 32'h0000_0001);
        wait_state(FE_HOME_DONE);
        @(posedge mclk_in);
        index_pulse_in <= 1'b0;
        home_switch_in <= 1'b0;
        @(negedge mclk_in);
        check(cur_pos_out, 32'h0000_0000 - ofs);
        check(home_speed_out, 32'h0000_0000);
        // moves afterwards are reckoned from the new zero
        @(posedge mclk_in);
        measured_pos_in <= b + 32'h0000_004d;
        repeat (3) @(negedge mclk_in);
        check(cur_pos_out, 32'h0000_004d - ofs);
        @(posedge mclk_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        reset_in <= 1'b0;
        rd_reg(`FE_IDX_POS_PROF, 32'h0000_0000);
        @(negedge mclk_in);
        check(32'(pos_profile_out), 32'h0000_0000);
        check(32'(notes.size()), 32'h0000_0000);
        wrap_up();
    end
endmodule : following_error_homing_params_test
